// ===== design/adc_conversion_control_map.svh
// Purpose: Offsets, field positions, reset values and timing figures of the converter control block
// Assumes: Register offsets are word indices; byte address is four times the index
// Notes: Definitions only
`ifndef ADC_CONVERSION_CONTROL_MAP_SVH
`define ADC_CONVERSION_CONTROL_MAP_SVH

`define IDX_CONV_CONTROL 16'hFE58
`define IDX_CONV_MODE 16'hFE59
`define IDX_RESULT_LOW 16'hFE5A
`define IDX_RESULT_HIGH 16'hFE5B
`define IDX_REF_VOLTAGE_CONTROL 16'hFEC0
`define IDX_REF_LOW_TRIM 16'hFEC1
`define IDX_ANALOG_PIN_DISABLE 16'hFEC2
`define IDX_AMPLIFIER_CONTROL 16'hFEC3
`define IDX_REF_HIGH_TRIM 16'hFEC6

`define CTRL_CHAN_HI 7
`define CTRL_CHAN_LO 4
`define CTRL_RUN 2
`define CTRL_DONE 1
`define CTRL_IRQ_EN 0
`define MODE_RES_8BIT 6
`define MODE_TM_MID 1
`define MODE_TM_LSB 0
`define LOW_TM_MSB 0
`define LOW_DATA_HI 7
`define LOW_DATA_LO 4
`define REF_CORE_ON 7
`define REF_OUTPUT_ON 6
`define REF_COMPARATOR_ON 5
`define REF_ADC_SEL 1
`define REF_LEVEL_SEL 0

`define CTRL_MASK 8'hF7
`define MODE_MASK 8'h43
`define LOW_MASK 8'hF1
`define HIGH_MASK 8'hFF
`define REF_CTRL_MASK 8'hE3
`define PIN_DISABLE_MASK 8'hFF
`define AMP_CTRL_MASK 8'hD7
`define TRIM_MASK 8'hFF

`define BYTE_RESET 8'h00
`define TRIM_RESET 8'h00

// Conversion time counted in thirds of a cycle time, one per clock
`define CONV_UNITS_12BIT 15'h0034
`define CONV_UNITS_8BIT 15'h0020
`define CONV_UNITS_EXTRA 15'h0002

`endif

// ===== design/adc_conversion_control_pkg.sv
// Purpose: Types shared by the converter control block
// Assumes: Constants live in the map header
// Notes: Nothing here is imported; users write the package name
package adc_conversion_control_pkg;

    typedef enum logic {
        conv_idle,
        conv_busy
    } conv_state_t;

    typedef struct packed {
        logic write;
        logic [15:0] index;
        logic [7:0] data;
    } reg_write_t;

    typedef struct packed {
        logic twelve_bit;
        logic [2:0] ratio_code;
        logic first;
    } conv_setup_t;

    typedef struct packed {
        logic core_on;
        logic output_on;
        logic comparator_on;
        logic adc_ref_sel;
        logic ref_level_sel;
    } ref_enables_t;

endpackage

// ===== design/conv_timer.sv
// Purpose: Counts out one conversion time
// Assumes: One clock is one third of a cycle time
// Notes: Abort wins over completion
`include "adc_conversion_control_map.svh"

module conv_timer (
    input logic mclk_in,
    input logic rst_in,
    input logic start_in,
    input logic abort_in,
    input adc_conversion_control_pkg::conv_setup_t setup_in,
    output logic done_out
);

    logic busy;
    logic [14:0] remaining;
    logic next_busy;
    logic [14:0] next_remaining;
    logic next_done;

    function automatic logic [14:0] conv_cycles(input adc_conversion_control_pkg::conv_setup_t s);
        logic [14:0] base;
        logic [14:0] units;
        base = s.twelve_bit ? `CONV_UNITS_12BIT : `CONV_UNITS_8BIT;
        units = (base << s.ratio_code) + `CONV_UNITS_EXTRA;
        if (s.twelve_bit && s.first) begin
            units = units << 1;
        end
        conv_cycles = units;
    endfunction

    always_comb begin
        next_busy = busy;
        next_remaining = remaining;
        next_done = 1'b0;
        if (start_in) begin
            next_busy = 1'b1;
            next_remaining = conv_cycles(setup_in) - 15'h0001;
        end else if (abort_in) begin
            next_busy = 1'b0;
        end else if (busy) begin
            if (remaining == 15'h0000) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_remaining = remaining - 15'h0001;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            busy <= 1'b0;
            remaining <= 15'h0000;
            done_out <= 1'b0;
        end else begin
            busy <= next_busy;
            remaining <= next_remaining;
            done_out <= next_done;
        end
    end

endmodule

// ===== design/ref_voltage_regs.sv
// Purpose: Reference voltage, trim, pin disable and amplifier register bank
// Assumes: Writes arrive already decoded to a word index
// Notes: Comparator needs the core reference as well
`include "adc_conversion_control_map.svh"

module ref_voltage_regs (
    input logic mclk_in,
    input logic rst_in,
    input adc_conversion_control_pkg::reg_write_t wr_in,
    input logic [15:0] rd_index_in,
    output logic [7:0] rd_data_out,
    output logic rd_hit_out,
    output adc_conversion_control_pkg::ref_enables_t enables_out,
    output logic [7:0] low_trim_out,
    output logic [7:0] high_trim_out,
    output logic [7:0] pin_disable_out,
    output logic [7:0] amp_control_out
);

    logic [7:0] bank [0:4];
    logic [7:0] next_bank [0:4];
    adc_conversion_control_pkg::ref_enables_t next_enables;

    function automatic logic [3:0] slot_of(input logic [15:0] index);
        unique case (index)
            `IDX_REF_VOLTAGE_CONTROL: slot_of = 4'h8;
            `IDX_REF_LOW_TRIM: slot_of = 4'h9;
            `IDX_ANALOG_PIN_DISABLE: slot_of = 4'hA;
            `IDX_AMPLIFIER_CONTROL: slot_of = 4'hB;
            `IDX_REF_HIGH_TRIM: slot_of = 4'hC;
            default: slot_of = 4'h0;
        endcase
    endfunction

    function automatic logic [7:0] mask_of(input logic [2:0] slot);
        unique case (slot)
            3'h0: mask_of = `REF_CTRL_MASK;
            3'h2: mask_of = `PIN_DISABLE_MASK;
            3'h3: mask_of = `AMP_CTRL_MASK;
            default: mask_of = `TRIM_MASK;
        endcase
    endfunction

    always_comb begin
        logic [3:0] ws;
        logic [3:0] rs;
        ws = slot_of(wr_in.index);
        rs = slot_of(rd_index_in);
        for (int i = 0; i < 5; i++) begin
            next_bank[i] = bank[i];
        end
        if (wr_in.write && ws[3]) begin
            next_bank[ws[2:0]] = wr_in.data & mask_of(ws[2:0]);
        end
        rd_hit_out = rs[3];
        rd_data_out = rs[3] ? bank[rs[2:0]] : `BYTE_RESET;
        next_enables.core_on = next_bank[0][`REF_CORE_ON];
        next_enables.output_on = next_bank[0][`REF_OUTPUT_ON];
        next_enables.comparator_on = next_bank[0][`REF_COMPARATOR_ON] & next_bank[0][`REF_CORE_ON];
        next_enables.adc_ref_sel = next_bank[0][`REF_ADC_SEL];
        next_enables.ref_level_sel = next_bank[0][`REF_LEVEL_SEL];
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            bank[0] <= `BYTE_RESET;
            bank[1] <= `TRIM_RESET;
            bank[2] <= `BYTE_RESET;
            bank[3] <= `BYTE_RESET;
            bank[4] <= `TRIM_RESET;
            enables_out <= '0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                bank[i] <= next_bank[i];
            end
            enables_out <= next_enables;
        end
    end

    assign low_trim_out = bank[1];
    assign pin_disable_out = bank[2];
    assign amp_control_out = bank[3];
    assign high_trim_out = bank[4];

endmodule

// ===== design/adc_conversion_control.sv
// Purpose: Conversion control for the successive-approximation converter, plus reference register bank
// Assumes: Analog core result is on this clock; one clock is one third of a cycle time
// Notes: Avalon-MM slave with waitrequest, 8-bit registers in the low byte lane
//
// Chosen here: the Avalon-MM register port.
`include "adc_conversion_control_map.svh"

module adc_conversion_control (
    input logic mclk_in,
    input logic rst_in,
    input logic [17:0] avs_address_in,
    input logic avs_read_in,
    input logic avs_write_in,
    input logic [31:0] avs_writedata_in,
    input logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input logic [11:0] conv_result_in,
    output logic conv_active_out,
    output logic [3:0] analog_channel_out,
    output logic resolution_8bit_out,
    output logic conv_irq_out,
    output logic ref_core_on_out,
    output logic ref_output_on_out,
    output logic comparator_on_out,
    output logic adc_ref_sel_out,
    output logic ref_level_sel_out,
    output logic [7:0] ref_low_trim_out,
    output logic [7:0] ref_high_trim_out,
    output logic [7:0] pin_digital_disable_out,
    output logic [7:0] amplifier_control_out
);

    // Bus slave state
    logic waitrequest;
    logic [31:0] readdata;
    logic next_waitrequest;
    logic [31:0] next_readdata;

    // Conversion state
    adc_conversion_control_pkg::conv_state_t state;
    adc_conversion_control_pkg::conv_state_t next_state;
    logic [7:0] converter_control_reg;
    logic [7:0] converter_mode_reg;
    logic [7:0] result_low_byte;
    logic [7:0] result_high_byte;
    logic first_conv;
    logic conv_twelve;
    logic active;
    logic irq;
    logic [7:0] next_control;
    logic [7:0] next_mode;
    logic [7:0] next_low;
    logic [7:0] next_high;
    logic next_first;
    logic next_conv_twelve;
    logic next_active;
    logic next_irq;

    // Decode and strobes
    logic [15:0] index;
    logic [7:0] wdata;
    logic wr_accept;
    logic rd_capture;
    logic wr_control;
    logic wr_mode;
    logic wr_low;
    logic wr_high;
    logic [7:0] local_rd;
    logic local_hit;
    logic [7:0] ref_rd;
    logic ref_hit;

    // Sequencing
    logic start;
    logic abort;
    logic complete;
    logic timer_done;
    logic twelve_selected;
    adc_conversion_control_pkg::conv_setup_t setup;
    adc_conversion_control_pkg::reg_write_t ref_wr;
    adc_conversion_control_pkg::ref_enables_t ref_en;

    // Word index compare
    function automatic logic is_index(input logic [15:0] idx, input logic [15:0] target);
        is_index = (idx == target);
    endfunction

    assign index = avs_address_in[17:2];
    assign wdata = avs_writedata_in[7:0];
    // Write lands only on the edge where waitrequest is seen low
    assign wr_accept = avs_write_in && !waitrequest && avs_byteenable_in[0];
    // Latch on request edge
    assign rd_capture = avs_read_in && waitrequest;
    assign wr_control = wr_accept && is_index(index, `IDX_CONV_CONTROL);
    assign wr_mode = wr_accept && is_index(index, `IDX_CONV_MODE);
    assign wr_low = wr_accept && is_index(index, `IDX_RESULT_LOW);
    assign wr_high = wr_accept && is_index(index, `IDX_RESULT_HIGH);

    always_comb begin
        ref_wr.write = wr_accept;
        ref_wr.index = index;
        ref_wr.data = wdata;
    end

    // Bank takes all writes
    ref_voltage_regs u_ref_voltage_regs (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .wr_in(ref_wr),
        .rd_index_in(index),
        .rd_data_out(ref_rd),
        .rd_hit_out(ref_hit),
        .enables_out(ref_en),
        .low_trim_out(ref_low_trim_out),
        .high_trim_out(ref_high_trim_out),
        .pin_disable_out(pin_digital_disable_out),
        .amp_control_out(amplifier_control_out)
    );

    // Local readback
    always_comb begin
        local_hit = 1'b1;
        unique case (index)
            `IDX_CONV_CONTROL: local_rd = converter_control_reg;
            `IDX_CONV_MODE: local_rd = converter_mode_reg;
            `IDX_RESULT_LOW: local_rd = result_low_byte;
            `IDX_RESULT_HIGH: local_rd = result_high_byte;
            default: begin
                local_hit = 1'b0;
                local_rd = `BYTE_RESET;
            end
        endcase
    end

    // Fixed one-wait-state answer; unmapped reads give zero
    always_comb begin
        next_waitrequest = !((avs_read_in || avs_write_in) && waitrequest);
        next_readdata = readdata;
        if (rd_capture) begin
            if (local_hit) begin
                next_readdata = {24'h000000, local_rd};
            end else if (ref_hit) begin
                next_readdata = {24'h000000, ref_rd};
            end else begin
                next_readdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else begin
            waitrequest <= next_waitrequest;
            readdata <= next_readdata;
        end
    end

    // Mode bit high is eight-bit
    assign twelve_selected = !converter_mode_reg[`MODE_RES_8BIT];
    // Busy ignores run rewrites
    assign start = (state == adc_conversion_control_pkg::conv_idle) && converter_control_reg[`CTRL_RUN];
    // Run cleared while busy
    assign abort = (state == adc_conversion_control_pkg::conv_busy) && !converter_control_reg[`CTRL_RUN];
    // Abort beats completion
    assign complete = (state == adc_conversion_control_pkg::conv_busy) && timer_done && !abort;

    // Code spans two registers
    always_comb begin
        setup.twelve_bit = twelve_selected;
        setup.ratio_code = {result_low_byte[`LOW_TM_MSB],
                            converter_mode_reg[`MODE_TM_MID],
                            converter_mode_reg[`MODE_TM_LSB]};
        setup.first = first_conv;
    end

    // Timer owns the count
    conv_timer u_conv_timer (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .start_in(start),
        .abort_in(abort),
        .setup_in(setup),
        .done_out(timer_done)
    );

    // Abort and end go idle
    always_comb begin
        next_state = state;
        unique case (state)
            adc_conversion_control_pkg::conv_idle: begin
                if (start) begin
                    next_state = adc_conversion_control_pkg::conv_busy;
                end
            end
            adc_conversion_control_pkg::conv_busy: begin
                if (abort || complete) begin
                    next_state = adc_conversion_control_pkg::conv_idle;
                end
            end
        endcase
    end

    // Done may be written too
    always_comb begin
        next_control = converter_control_reg;
        if (wr_control) begin
            next_control = wdata & `CTRL_MASK;
        end
        // Completion after the write so an event in the clearing cycle survives
        if (complete) begin
            next_control[`CTRL_RUN] = 1'b0;
            next_control[`CTRL_DONE] = 1'b1;
        end
        next_irq = next_control[`CTRL_DONE] && next_control[`CTRL_IRQ_EN];
    end

    // 12-to-8 keeps marker
    always_comb begin
        next_mode = converter_mode_reg;
        next_first = first_conv;
        if (complete && conv_twelve) begin
            next_first = 1'b0;
        end
        if (wr_mode) begin
            next_mode = wdata & `MODE_MASK;
            if (converter_mode_reg[`MODE_RES_8BIT] && !wdata[`MODE_RES_8BIT]) begin
                next_first = 1'b1;
            end
        end
    end

    // Width latched at start
    always_comb begin
        next_low = result_low_byte;
        next_high = result_high_byte;
        next_conv_twelve = conv_twelve;
        if (start) begin
            next_conv_twelve = twelve_selected;
        end
        if (wr_low) begin
            next_low = wdata & `LOW_MASK;
        end
        if (wr_high) begin
            next_high = wdata & `HIGH_MASK;
        end
        // Converter output only trusted at completion
        if (complete) begin
            next_high = conv_result_in[11:4];
            if (conv_twelve) begin
                next_low[`LOW_DATA_HI:`LOW_DATA_LO] = conv_result_in[3:0];
            end
        end
        next_active = (next_state == adc_conversion_control_pkg::conv_busy);
    end

    // Sequencing
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= adc_conversion_control_pkg::conv_idle;
            active <= 1'b0;
        end else begin
            state <= next_state;
            active <= next_active;
        end
    end

    // Control
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            converter_control_reg <= `BYTE_RESET;
            irq <= 1'b0;
        end else begin
            converter_control_reg <= next_control;
            irq <= next_irq;
        end
    end

    // Mode
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            converter_mode_reg <= `BYTE_RESET;
            first_conv <= 1'b1;
        end else begin
            converter_mode_reg <= next_mode;
            first_conv <= next_first;
        end
    end

    // Results
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            result_low_byte <= `BYTE_RESET;
            result_high_byte <= `BYTE_RESET;
            conv_twelve <= 1'b0;
        end else begin
            result_low_byte <= next_low;
            result_high_byte <= next_high;
            conv_twelve <= next_conv_twelve;
        end
    end

    // All outputs registered
    assign avs_readdata_out = readdata;
    assign avs_waitrequest_out = waitrequest;
    assign conv_active_out = active;
    assign analog_channel_out = converter_control_reg[`CTRL_CHAN_HI:`CTRL_CHAN_LO];
    assign resolution_8bit_out = converter_mode_reg[`MODE_RES_8BIT];
    assign conv_irq_out = irq;
    assign ref_core_on_out = ref_en.core_on;
    assign ref_output_on_out = ref_en.output_on;
    assign comparator_on_out = ref_en.comparator_on;
    assign adc_ref_sel_out = ref_en.adc_ref_sel;
    assign ref_level_sel_out = ref_en.ref_level_sel;

endmodule

// ===== verification/analog_core_model.sv
// Purpose: Stand-in for the analog converter core
// Assumes: The block samples the result on its completion edge
// Notes: Idle output toggles, so a stale sample never looks valid
module analog_core_model (
    input logic mclk_in,
    input logic rst_in,
    input logic active_in,
    input logic [3:0] channel_in,
    output logic [11:0] result_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic was;
    logic [3:0] runs;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            was <= 1'b0;
            runs <= 4'h0;
            result_out <= 12'h5A5;
        end else begin
            was <= active_in;
            runs <= runs + 4'(was && !active_in);
            result_out <= active_in ? {channel_in, runs, 4'h9} : ~result_out;
        end
    end
endmodule

// ===== verification/adc_conversion_control_checker.sv
// Purpose: Port assertions for the converter control block
// Assumes: A write lands at the edge that sees waitrequest low
// Notes: Outputs judged two edges on, allowing one output stage
`include "adc_conversion_control_map.svh"
module adc_conversion_control_checker (
    input logic mclk_in,
    input logic rst_in,
    input logic [17:0] avs_address_in,
    input logic avs_read_in,
    input logic avs_write_in,
    input logic [31:0] avs_writedata_in,
    input logic [3:0] avs_byteenable_in,
    input logic avs_waitrequest_out,
    input logic conv_active_out,
    input logic [3:0] analog_channel_out,
    input logic resolution_8bit_out,
    input logic conv_irq_out,
    input logic ref_core_on_out,
    input logic ref_output_on_out,
    input logic comparator_on_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr;
    logic [15:0] idx;
    assign wr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    assign idx = avs_address_in[17:2];
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    property p_ans; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
    a_ans: assert property (p_ans) else $error("no answer after one wait cycle");
    property p_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    a_one: assert property (p_one) else $error("waitrequest low too long");
    property p_ref; wr && idx == `IDX_REF_VOLTAGE_CONTROL |=> ##1
        {ref_core_on_out, ref_output_on_out} == $past(avs_writedata_in[7:6], 2); endproperty
    a_ref: assert property (p_ref) else $error("reference enables wrong");
    property p_comp; comparator_on_out |-> ref_core_on_out; endproperty
    a_comp: assert property (p_comp) else $error("comparator on without core reference");
    property p_chan; wr && idx == `IDX_CONV_CONTROL |=> ##1 analog_channel_out == $past(avs_writedata_in[7:4], 2);
    endproperty
    a_chan: assert property (p_chan) else $error("channel select wrong");
    property p_res; wr && idx == `IDX_CONV_MODE |=> ##1 resolution_8bit_out == $past(avs_writedata_in[6], 2);
    endproperty
    a_res: assert property (p_res) else $error("resolution wrong");
    property p_start; wr && idx == `IDX_CONV_CONTROL && avs_writedata_in[2] && !conv_active_out |-> ##2 conv_active_out;
    endproperty
    a_start: assert property (p_start) else $error("run did not start");
    property p_stop; wr && idx == `IDX_CONV_CONTROL && !avs_writedata_in[2] |-> ##2 !conv_active_out; endproperty
    a_stop: assert property (p_stop) else $error("run did not stop");
    property p_irq; $rose(conv_irq_out) |-> $fell(conv_active_out); endproperty
    a_irq: assert property (p_irq) else $error("request not at conversion end");
endmodule

bind adc_conversion_control adc_conversion_control_checker adc_conversion_control_checker_i (
    .mclk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
    .avs_waitrequest_out, .conv_active_out, .analog_channel_out, .resolution_8bit_out, .conv_irq_out,
    .ref_core_on_out, .ref_output_on_out, .comparator_on_out
);

// ===== verification/tb_adc_conversion_control.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: One wait cycle per bus request
// Notes: Active count is conversion time plus one
`include "adc_conversion_control_map.svh"
module tb_adc_conversion_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in;
    logic rst_in;
    logic [17:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0] avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [11:0] conv_result_in;
    logic conv_active_out;
    logic [3:0] analog_channel_out;
    logic resolution_8bit_out, conv_irq_out, ref_core_on_out, ref_output_on_out;
    logic comparator_on_out, adc_ref_sel_out, ref_level_sel_out;
    logic [7:0] ref_low_trim_out, ref_high_trim_out, pin_digital_disable_out, amplifier_control_out;
    int failures;
    int checked;
    logic [7:0] low_exp;
    logic [7:0] high_exp;

    adc_conversion_control adc_conversion_control_i (.mclk_in, .rst_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
        .conv_result_in, .conv_active_out, .analog_channel_out, .resolution_8bit_out, .conv_irq_out,
        .ref_core_on_out, .ref_output_on_out, .comparator_on_out, .adc_ref_sel_out, .ref_level_sel_out,
        .ref_low_trim_out, .ref_high_trim_out, .pin_digital_disable_out, .amplifier_control_out);
    analog_core_model analog_core_model_i (.mclk_in, .rst_in, .active_in(conv_active_out),
        .channel_in(analog_channel_out), .result_out(conv_result_in));

    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end

    task automatic complete_run;
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] wd, input logic be,
        output logic [7:0] r);
        int n;
        n = 0;
        @(posedge mclk_in);
        avs_address_in <= {a, 2'b00};
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_writedata_in <= {24'h000000, wd};
        avs_byteenable_in <= {3'b111, be};
        do begin
            @(posedge mclk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 64);
        if (avs_waitrequest_out !== 1'b0) begin
            failures++;
            complete_run();
        end
        r = avs_readdata_out[7:0];
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, 1'b1, r);
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, 1'b1, r);
        check(r, e);
    endtask

    task automatic regs;
        logic [15:0] idx [8];
        logic [7:0] msk [8];
        idx = '{`IDX_CONV_MODE, `IDX_RESULT_LOW, `IDX_RESULT_HIGH, `IDX_REF_VOLTAGE_CONTROL,
            `IDX_REF_LOW_TRIM, `IDX_ANALOG_PIN_DISABLE, `IDX_AMPLIFIER_CONTROL, `IDX_REF_HIGH_TRIM};
        msk = '{8'h43, 8'hF1, 8'hFF, 8'hE3, 8'hFF, 8'hFF, 8'hD7, 8'hFF};
        rdc(`IDX_CONV_CONTROL, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rdc(idx[i], 8'h00);
            wr(idx[i], 8'hFF);
            rdc(idx[i], msk[i]);
        end
        repeat (2) @(negedge mclk_in);
        check({ref_core_on_out, ref_output_on_out, comparator_on_out,
            adc_ref_sel_out, ref_level_sel_out}, 5'h1F);
        check({ref_low_trim_out, ref_high_trim_out, pin_digital_disable_out, amplifier_control_out}, 32'hFFFFFFD7);
        bus(1'b1, `IDX_REF_VOLTAGE_CONTROL, 8'h00, 1'b0, low_exp);
        rdc(`IDX_REF_VOLTAGE_CONTROL, 8'hE3);
        wr(`IDX_REF_VOLTAGE_CONTROL, 8'h20);
        repeat (2) @(negedge mclk_in);
        check({ref_core_on_out, ref_output_on_out, comparator_on_out,
            adc_ref_sel_out, ref_level_sel_out}, 5'h00);
        wr(16'h0100, 8'hFF);
        rdc(16'h0100, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(idx[i], 8'h00);
        end
        low_exp = 8'h00;
    endtask

    task automatic conv(input logic eb, input logic [2:0] c, input logic [3:0] ch, input logic ie, input int exp);
        int n;
        logic [11:0] res;
        n = 0;
        res = 12'h000;
        low_exp = {low_exp[7:4], 3'b000, c[2]};
        wr(`IDX_RESULT_LOW, low_exp);
        wr(`IDX_CONV_MODE, {1'b0, eb, 4'h0, c[1:0]});
        wr(`IDX_CONV_CONTROL, {ch, 3'b010, ie});
        @(negedge mclk_in);
        do begin
            @(negedge mclk_in);
            if (conv_active_out === 1'b1) begin
                n++;
                res = conv_result_in;
            end
        end while (conv_active_out === 1'b1 && n < 9000);
        if (n == 9000) begin
            failures++;
            complete_run();
        end
        check(n, exp);
        check(conv_irq_out, ie);
        rdc(`IDX_CONV_CONTROL, {ch, 3'b001, ie});
        high_exp = res[11:4];
        if (!eb) begin
            low_exp = {res[3:0], 3'b000, c[2]};
        end
        rdc(`IDX_RESULT_HIGH, high_exp);
        rdc(`IDX_RESULT_LOW, low_exp);
        wr(`IDX_CONV_CONTROL, {ch, 3'b000, ie});
        repeat (2) @(negedge mclk_in);
        check(conv_irq_out, 1'b0);
    endtask

    initial begin
        rst_in = 1'b1;
        avs_address_in = 18'h00000;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h00000000;
        avs_byteenable_in = 4'hF;
        failures = 0;
        checked = 0;
        low_exp = 8'h00;
        high_exp = 8'h00;
        repeat (16) @(posedge mclk_in);
        rst_in <= 1'b0;
        regs();
        conv(1'b0, 3'h5, 4'h5, 1'b1, 3333);
        conv(1'b0, 3'h0, 4'h2, 1'b0, 55);
        for (int c = 0; c < 8; c++) begin
            conv(1'b1, c[2:0], 4'h7, 1'b0, (32 << c) + 3);
        end
        conv(1'b0, 3'h0, 4'h9, 1'b0, 109);
        wr(`IDX_CONV_MODE, 8'h03);
        wr(`IDX_CONV_CONTROL, 8'hA4);
        repeat (20) @(posedge mclk_in);
        wr(`IDX_CONV_CONTROL, 8'hA0);
        repeat (2) @(negedge mclk_in);
        check(conv_active_out, 1'b0);
        repeat (500) @(posedge mclk_in);
        rdc(`IDX_CONV_CONTROL, 8'hA0);
        rdc(`IDX_RESULT_HIGH, high_exp);
        rdc(`IDX_RESULT_LOW, low_exp);
        wr(`IDX_CONV_CONTROL, 8'h34);
        repeat (10) @(posedge mclk_in);
        rst_in <= 1'b1;
        @(negedge mclk_in);
        check(conv_active_out, 1'b0);
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        rdc(`IDX_CONV_CONTROL, 8'h00);
        low_exp = 8'h00;
        conv(1'b0, 3'h0, 4'h3, 1'b0, 109);
        complete_run();
    end
endmodule
